// File: eriv_pkg.sv
// package: constants and types for the emergency rod insertion voting block
package eriv_pkg;
    // ==========================================
    // widths and counts
    localparam int unsigned REDUNDANCY   = 3;
    localparam int unsigned CHANNELS     = 2;
    localparam int unsigned DRIVE_DEF    = 4;
    localparam int unsigned POS_W        = 8;

    // ==========================================
    // values after reset, and the full-in target
    localparam logic [POS_W-1:0] FULL_IN_POS   = 8'h00;
    localparam logic [POS_W-1:0] RESET_POS     = 8'hFF;
    localparam logic             RESET_LEVEL   = 1'b0;

    // ==========================================
    // run-in mode, one shared by all motors
    typedef enum logic [1:0] {
        ERIV_IDLE     = 2'b00,
        ERIV_SELECTED = 2'b01,
        ERIV_FULL_IN  = 2'b11
    } eriv_mode_t;

    typedef logic [REDUNDANCY-1:0] eriv_trio_t;
endpackage : eriv_pkg

// File: eriv_vote.sv
// module: two-out-of-three majority vote, combinational
`timescale 1ns/100ps
module eriv_vote (
    input  wire logic [2:0] votes,
    output logic            pass
);
    // ==========================================
    // majority function
    always_comb begin
        pass = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]); // R10
    end
endmodule : eriv_vote

// File: eriv_top.sv
// module: voting and gating of backup and selected rod run-in toward motor drivers
//
// Overview of operation
// R01 - vote three backup requests into one initiation
// R02 - each rod action channel votes backup commands
// R03 - backup active drives operable motors full in
// R04 - backup request only comes with scram
// R05 - emergency insertion is selected OR backup
// R06 - vote emergency signals, drive condition outputs
// R07 - run-in needs condition and channel command
// R08 - vote each selected-run-in group, then OR
// R09 - selected run-in goes to predefined positions
// R10 - majority true when two of three true
`timescale 1ns/100ps
module eriv_top
    import eriv_pkg::*;
#(
    parameter int unsigned DRIVES = eriv_pkg::DRIVE_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire eriv_pkg::eriv_trio_t     diverse_protection_runin,
    input  wire eriv_pkg::eriv_trio_t     diverse_protection_scram,
    input  wire eriv_pkg::eriv_trio_t     heating_loss,
    input  wire eriv_pkg::eriv_trio_t     turbine_trip,
    input  wire eriv_pkg::eriv_trio_t     load_reject,
    input  wire logic [DRIVES-1:0]        drive_operable,
    input  wire logic [DRIVES*eriv_pkg::POS_W-1:0] selected_target,
    output logic                          backup_initiation,
    output logic                          selected_runin,
    output logic [eriv_pkg::CHANNELS-1:0] backup_motor_runin,
    output logic [eriv_pkg::CHANNELS-1:0] selected_channel_runin,
    output logic                          emergency_condition,
    output logic                          scram_conflict,
    output logic [DRIVES-1:0]             rod_drive_motor_run,
    output logic [DRIVES*eriv_pkg::POS_W-1:0] rod_drive_motor_target
);
    import eriv_pkg::*;

    // ==========================================
    // input synchronisers, two flops each
    localparam int unsigned NIN = 5 * REDUNDANCY + DRIVES;
    logic [NIN-1:0]          sync_a;
    logic [NIN-1:0]          sync_b;
    // target words are quasi-static; per-bit skew only matters while they move
    logic [DRIVES*POS_W-1:0] tgt_a;
    logic [DRIVES*POS_W-1:0] tgt_b;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
            tgt_a  <= '0;
            tgt_b  <= '0;
        end else begin
            sync_a <= {drive_operable, load_reject, turbine_trip, heating_loss,
                       diverse_protection_scram, diverse_protection_runin};
            sync_b <= sync_a;
            tgt_a  <= selected_target;
            tgt_b  <= tgt_a;
        end
    end

    logic [2:0]        s_runin;
    logic [2:0]        s_scram;
    logic [2:0]        s_heat;
    logic [2:0]        s_trip;
    logic [2:0]        s_rej;
    logic [DRIVES-1:0] s_oper;
    assign s_runin = sync_b[2:0];
    assign s_scram = sync_b[5:3];
    assign s_heat  = sync_b[8:6];
    assign s_trip  = sync_b[11:9];
    assign s_rej   = sync_b[14:12];
    assign s_oper  = sync_b[NIN-1:15];

    // ==========================================
    // first level votes
    logic v_runin;
    logic v_scram;
    logic v_heat;
    logic v_trip;
    logic v_rej;

    eriv_vote u_vote_runin (.votes(s_runin), .pass(v_runin)); // R01
    eriv_vote u_vote_scram (.votes(s_scram), .pass(v_scram));
    eriv_vote u_vote_heat  (.votes(s_heat),  .pass(v_heat));  // R08
    eriv_vote u_vote_trip  (.votes(s_trip),  .pass(v_trip));  // R08
    eriv_vote u_vote_rej   (.votes(s_rej),   .pass(v_rej));   // R08

    // registered stage one; three redundant copies feed the next votes
    logic [2:0] backup_cmd;
    logic [2:0] selected_cmd;
    logic [2:0] emergency_sig;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            backup_cmd   <= '0;
            selected_cmd <= '0;
        end else begin
            backup_cmd   <= {3{v_runin}};                    // R01
            selected_cmd <= {3{v_heat | v_trip | v_rej}};    // R08
        end
    end

    assign emergency_sig = selected_cmd | backup_cmd;        // R05

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            backup_initiation <= RESET_LEVEL;
            selected_runin    <= RESET_LEVEL;
            scram_conflict    <= RESET_LEVEL;
        end else begin
            backup_initiation <= v_runin;                    // R01
            selected_runin    <= v_heat | v_trip | v_rej;    // R08
            // flags a far end that requests backup without scram
            scram_conflict    <= v_runin & ~v_scram;         // R04
        end
    end

    // ==========================================
    // rod action channels and emergency panel
    logic [CHANNELS-1:0] ch_backup;
    logic [CHANNELS-1:0] ch_select;
    logic                emerg_pass;

    genvar gc;
    generate
        for (gc = 0; gc < CHANNELS; gc++) begin : g_chan
            eriv_vote u_vb (.votes(backup_cmd),   .pass(ch_backup[gc])); // R02
            eriv_vote u_vs (.votes(selected_cmd), .pass(ch_select[gc]));
        end
    endgenerate

    eriv_vote u_vote_emerg (.votes(emergency_sig), .pass(emerg_pass)); // R06

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            backup_motor_runin     <= '0;
            selected_channel_runin <= '0;
            emergency_condition    <= RESET_LEVEL;
        end else begin
            backup_motor_runin     <= ch_backup;   // R02
            selected_channel_runin <= ch_select;
            emergency_condition    <= emerg_pass;  // R06
        end
    end

    // ==========================================
    // motor drivers: run only with condition and channel command
    logic any_backup;
    logic any_select;
    assign any_backup = |backup_motor_runin;
    assign any_select = |selected_channel_runin;

    eriv_mode_t mode;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= ERIV_IDLE;
        end else begin
            case (1'b1)
                // full insertion outranks the partial selected run-in
                emergency_condition & any_backup: mode <= ERIV_FULL_IN;   // R07
                emergency_condition & any_select: mode <= ERIV_SELECTED;  // R07
                default:                          mode <= ERIV_IDLE;
            endcase
        end
    end

    genvar gd;
    generate
        for (gd = 0; gd < DRIVES; gd++) begin : g_drive
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    rod_drive_motor_run[gd] <= RESET_LEVEL;
                    rod_drive_motor_target[gd*POS_W +: POS_W] <= RESET_POS;
                end else begin
                    case (mode)
                        ERIV_FULL_IN: begin
                            rod_drive_motor_run[gd] <= s_oper[gd];                  // R03
                            rod_drive_motor_target[gd*POS_W +: POS_W] <= FULL_IN_POS; // R03
                        end
                        ERIV_SELECTED: begin
                            rod_drive_motor_run[gd] <= s_oper[gd];
                            rod_drive_motor_target[gd*POS_W +: POS_W] <=
                                tgt_b[gd*POS_W +: POS_W];                           // R09
                        end
                        default: begin
                            rod_drive_motor_run[gd] <= RESET_LEVEL;
                            rod_drive_motor_target[gd*POS_W +: POS_W] <= RESET_POS;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ==========================================
    // checks
    a_backup_vote: assert property (@(posedge clk) disable iff (!rst_n) // R01
        backup_initiation == $past(v_runin)) else $error("backup initiation not majority");
    a_channel_vote: assert property (@(posedge clk) disable iff (!rst_n) // R02
        v_runin |-> ##2 (backup_motor_runin == '1)) else $error("channel vote missed");
    a_full_in_target: assert property (@(posedge clk) disable iff (!rst_n) // R03
        mode == ERIV_FULL_IN |=> rod_drive_motor_target == '0) else $error("not full in");
    a_emerg_or: assert property (@(posedge clk) disable iff (!rst_n) // R05
        emerg_pass == (selected_cmd[0] | backup_cmd[0])) else $error("emergency not OR");
    a_cond_vote: assert property (@(posedge clk) disable iff (!rst_n) // R06
        (v_runin | v_heat | v_trip | v_rej) |-> ##2 emergency_condition) else $error("condition missed");
    a_run_gate: assert property (@(posedge clk) disable iff (!rst_n) // R07
        (|rod_drive_motor_run) |-> $past(mode) != ERIV_IDLE) else $error("run without gating");
    a_mode_gate: assert property (@(posedge clk) disable iff (!rst_n) // R07
        mode != ERIV_IDLE |-> $past(emergency_condition)) else $error("mode without condition");
    a_select_or: assert property (@(posedge clk) disable iff (!rst_n) // R08
        selected_runin == $past(v_heat | v_trip | v_rej)) else $error("selected run-in wrong");
    a_select_pos: assert property (@(posedge clk) disable iff (!rst_n) // R09
        mode == ERIV_SELECTED |=> rod_drive_motor_target == $past(tgt_b)) else $error("select target");
    a_majority: assert property (@(posedge clk) disable iff (!rst_n) // R10
        v_scram == ($countones(s_scram) >= 2)) else $error("majority wrong");
endmodule : eriv_top

// File: eriv_partner.sv
// diverse protection source model driving the backup run-in and scram lanes
`timescale 1ns/100ps
module eriv_partner (
    input  wire logic                 clk,
    input  wire eriv_pkg::eriv_trio_t want_runin,
    input  wire logic                 withhold_scram,
    output eriv_pkg::eriv_trio_t      runin,
    output eriv_pkg::eriv_trio_t      scram
);
    import eriv_pkg::*;
    // ==========================================
    // lanes
    // each run-in lane carries its scram lane with it; withholding is the fault case
    always_ff @(posedge clk) begin
        runin <= want_runin;
        scram <= withhold_scram ? 3'h0 : want_runin;
    end
endmodule : eriv_partner

// File: eriv_top_bench.sv
// self-checking bench for the rod insertion voting block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module eriv_top_bench;
    import eriv_pkg::*;
    logic       clk, rst_n, withhold, bk_init, sel_ri, emerg, conflict;
    eriv_trio_t want_runin, runin, scram, heat, trip, lrej;
    logic [3:0] oper, run;
    logic [1:0] bk_ch, sel_ch;
    logic [31:0] tgt_in, tgt;
    int         miscompares = 0, checked = 0, cycles = 0;

    eriv_partner PARTNER (.clk(clk), .want_runin(want_runin), .withhold_scram(withhold), .runin(runin), .scram(scram));
    eriv_top #(.DRIVES(4)) DUT (.clk(clk), .rst_n(rst_n), .diverse_protection_runin(runin),
        .diverse_protection_scram(scram), .heating_loss(heat), .turbine_trip(trip), .load_reject(lrej),
        .drive_operable(oper), .selected_target(tgt_in), .backup_initiation(bk_init),
        .selected_runin(sel_ri), .backup_motor_runin(bk_ch), .selected_channel_runin(sel_ch),
        .emergency_condition(emerg), .scram_conflict(conflict), .rod_drive_motor_run(run),
        .rod_drive_motor_target(tgt));

    // ==========================================
    // helpers
    function automatic logic maj(eriv_trio_t v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj

    // waits past the seven-edge partner-to-drive path with margin, then looks off the edge
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    task automatic check_out(logic bk, logic sl);
        logic [31:0] ex;
        logic        em;
        em = bk | sl;
        ex = 32'h0;
        // idle drives rest at the idle code; full-in outranks selected
        for (int i = 0; i < 4; i++) begin
            ex[8*i+:8] = !em ? RESET_POS : (bk ? FULL_IN_POS : tgt_in[8*i+:8]);
        end
        `CHK("backup_initiation", bk, bk_init)
        `CHK("backup_motor_runin", {2{bk}}, bk_ch)
        `CHK("selected_runin", sl, sel_ri)
        `CHK("selected_channel_runin", {2{sl}}, sel_ch)
        `CHK("emergency_condition", em, emerg)
        `CHK("rod_drive_motor_run", em ? oper : 4'h0, run)
        `CHK("rod_drive_motor_target", ex, tgt)
    endtask : check_out

    // ==========================================
    // scenarios
    task automatic t_backup();
        for (int p = 0; p < 8; p++) begin
            @(posedge clk);
            want_runin <= 3'(p);
            settle();
            check_out(maj(3'(p)), 1'b0);
        end
        @(posedge clk);
        want_runin <= 3'h0;
    endtask : t_backup

    task automatic t_selected();
        for (int g = 0; g < 3; g++) begin
            for (int p = 0; p < 8; p++) begin
                @(posedge clk);
                heat <= (g == 0) ? 3'(p) : 3'h0;
                trip <= (g == 1) ? 3'(p) : 3'h0;
                lrej <= (g == 2) ? 3'(p) : 3'h0;
                settle();
                check_out(1'b0, maj(3'(p)));
            end
        end
        @(posedge clk);
        lrej <= 3'h0;
    endtask : t_selected

    // full-in outranks selected; an inoperable drive stays still
    task automatic t_both();
        @(posedge clk);
        want_runin <= 3'h6;
        heat <= 3'h3;
        oper <= 4'h6;
        settle();
        check_out(1'b1, 1'b1);
        @(posedge clk);
        want_runin <= 3'h0;
        heat <= 3'h0;
        oper <= 4'hB;
    endtask : t_both

    task automatic t_conflict();
        @(posedge clk);
        withhold <= 1'b1;
        want_runin <= 3'h5;
        settle();
        `CHK("scram_conflict", 1'b1, conflict)
        check_out(1'b1, 1'b0);
        @(posedge clk);
        want_runin <= 3'h0;
        withhold <= 1'b0;
        settle();
        `CHK("scram_conflict", 1'b0, conflict)
    endtask : t_conflict

    // a mid-run reset drops every output at once, then the path refills
    task automatic t_reset();
        @(posedge clk);
        want_runin <= 3'h7;
        settle();
        check_out(1'b1, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        check_out(1'b0, 1'b0);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        check_out(1'b1, 1'b0);
        @(posedge clk);
        want_runin <= 3'h0;
        settle();
        check_out(1'b0, 1'b0);
    endtask : t_reset

    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ==========================================
    // clock, watchdog, sequence
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        rst_n = 1'b0;
        withhold = 1'b0;
        want_runin = 3'h0;
        heat = 3'h0;
        trip = 3'h0;
        lrej = 3'h0;
        oper = 4'hB;
        tgt_in = 32'h40302010;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        check_out(1'b0, 1'b0);
        t_backup();
        t_selected();
        t_both();
        t_conflict();
        t_reset();
        test_done();
    end
endmodule : eriv_top_bench
